// *** nv_memory_write_control.sv ***
// Purpose: Software control of writes and erases to nonvolatile storage.
// Assumes: Memory back end holds the request level until it pulses memDone.
// Notes: Register map and unlock keys are in nvm_pkg.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module nv_memory_write_control (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [4:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [4:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Device reset events
  input wire logic extResetPinEvent,
  input wire logic watchdogResetEvent,
  // Memory back end
  output logic memReq,
  output logic memErase,
  output logic [1:0] memSpace,
  output logic [9:0] memAddr,
  output logic [7:0] memData,
  input wire logic memDone,
  // Interrupt
  output logic irq
);
  typedef enum logic
  {
    IDLE = 1'b0,
    BUSY = 1'b1
  } op_t;

  op_t opState;
  logic awHeld;
  logic wHeld;
  logic [4:0] awaddrHeld;
  logic [31:0] wdataHeld;
  logic [3:0] wstrbHeld;
  logic pgmSel;
  logic cfgSel;
  logic eraseArm;
  logic abortFlag;
  logic writeAllow;
  logic [7:0] dataByte;
  logic [9:0] nvAddr;
  logic doneFlag;
  logic [7:0] enableReg;
  logic unlocked;

  wire busy = (opState == BUSY);
  wire resetEvt = extResetPinEvent | watchdogResetEvent;
  wire doWrite = ce && awHeld && wHeld && !bvalid;
  wire lane0 = wstrbHeld[0];
  wire wHitCtrl = (awaddrHeld == nvm_pkg::OFS_CTRL);
  wire wHitUnlock = (awaddrHeld == nvm_pkg::OFS_UNLOCK);
  wire wHitData = (awaddrHeld == nvm_pkg::OFS_DATA);
  wire wHitAddr = (awaddrHeld == nvm_pkg::OFS_ADDR);
  wire wHitStatus = (awaddrHeld == nvm_pkg::OFS_STATUS);
  wire wHitEnable = (awaddrHeld == nvm_pkg::OFS_ENABLE);
  wire wMapped = wHitCtrl | wHitUnlock | wHitData | wHitAddr | wHitStatus | wHitEnable;
  wire wrCtrl = doWrite && wHitCtrl && lane0;
  wire wrUnlock = doWrite && wHitUnlock && lane0;
  wire wrData = doWrite && wHitData && lane0;
  wire wrAddrLo = doWrite && wHitAddr && lane0;
  wire wrAddrHi = doWrite && wHitAddr && wstrbHeld[1];
  wire wrStatus = doWrite && wHitStatus && lane0;
  wire wrEnable = doWrite && wHitEnable && lane0;
  wire wrOther = doWrite && !wHitUnlock;
  wire trigReq = wrCtrl && wdataHeld[nvm_pkg::CTRL_TRIG_BIT];
  wire start = trigReq && writeAllow && unlocked && !busy && !resetEvt;
  wire finish = ce && busy && memDone && !resetEvt;
  wire doneClear = wrStatus && wdataHeld[nvm_pkg::DONE_BIT];
  wire [1:0] selSpace = cfgSel ? nvm_pkg::SPACE_CFG :
                        (pgmSel ? nvm_pkg::SPACE_PROG : nvm_pkg::SPACE_DATA);

  // Read decode; the unlock port has no storage behind it.
  wire rHitCtrl = (araddr == nvm_pkg::OFS_CTRL);
  wire rHitUnlock = (araddr == nvm_pkg::OFS_UNLOCK);
  wire rHitData = (araddr == nvm_pkg::OFS_DATA);
  wire rHitAddr = (araddr == nvm_pkg::OFS_ADDR);
  wire rHitStatus = (araddr == nvm_pkg::OFS_STATUS);
  wire rHitEnable = (araddr == nvm_pkg::OFS_ENABLE);
  wire rMapped = rHitCtrl | rHitUnlock | rHitData | rHitAddr | rHitStatus | rHitEnable;
  wire [7:0] ctrlView = {pgmSel, cfgSel, 1'b0, eraseArm, abortFlag, writeAllow, busy, 1'b0};
  wire [7:0] statusView = {3'h0, doneFlag, 4'h0};
  wire [31:0] readMux =
    rHitCtrl ? {24'h000000, ctrlView} :
    rHitData ? {24'h000000, dataByte} :
    rHitAddr ? {22'h0, nvAddr} :
    rHitStatus ? {24'h000000, statusView} :
    rHitEnable ? {24'h000000, enableReg} :
    32'h00000000;

  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awaddrHeld <= 5'h00;
      wdataHeld <= 32'h00000000;
      wstrbHeld <= 4'h0;
      bvalid <= 1'b0;
      bresp <= nvm_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        awHeld <= 1'b1;
        awaddrHeld <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld <= 1'b1;
        wdataHeld <= wdata;
        wstrbHeld <= wstrb;
      end
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wMapped ? nvm_pkg::RESP_OKAY : nvm_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= nvm_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata <= readMux;
        rresp <= rMapped ? nvm_pkg::RESP_OKAY : nvm_pkg::RESP_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  nv_unlock_seq unlockSeq (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .keyWrite(wrUnlock),
    .keyData(wdataHeld[7:0]),
    .breakSeq(wrOther | resetEvt),
    .consume(trigReq),
    .unlocked(unlocked)
  );

  // Control bits; a device reset event keeps only the abort flag history.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pgmSel <= 1'b0;
      cfgSel <= 1'b0;
      eraseArm <= 1'b0;
      abortFlag <= 1'b0;
      writeAllow <= 1'b0;
    end
    else if (ce && resetEvt)
    begin
      pgmSel <= 1'b0;
      cfgSel <= 1'b0;
      eraseArm <= 1'b0;
      writeAllow <= 1'b0;
      abortFlag <= abortFlag | busy;
    end
    else if (wrCtrl)
    begin
      pgmSel <= wdataHeld[nvm_pkg::CTRL_PGM_BIT];
      cfgSel <= wdataHeld[nvm_pkg::CTRL_CFG_BIT];
      eraseArm <= wdataHeld[nvm_pkg::CTRL_ERASE_BIT];
      abortFlag <= wdataHeld[nvm_pkg::CTRL_ABORT_BIT];
      writeAllow <= wdataHeld[nvm_pkg::CTRL_ALLOW_BIT];
    end
  end

  // The trigger bit is the busy state, so a written zero cannot cut an operation short.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      opState <= IDLE;
      memErase <= 1'b0;
      memSpace <= nvm_pkg::SPACE_DATA;
    end
    else if (ce)
    begin
      case (opState)
        IDLE:
          if (start)
          begin
            opState <= BUSY;
            memErase <= eraseArm;
            memSpace <= selSpace;
          end
        BUSY:
          if (memDone || resetEvt)
            opState <= IDLE;
        default:
          opState <= IDLE;
      endcase
    end
  end

  assign memReq = busy;
  assign memAddr = nvAddr;
  assign memData = dataByte;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      dataByte <= nvm_pkg::DATA_RST;
      nvAddr <= nvm_pkg::NV_ADDR_RST;
    end
    else if (ce && resetEvt)
    begin
      dataByte <= nvm_pkg::DATA_RST;
      nvAddr <= nvm_pkg::NV_ADDR_RST;
    end
    else
    begin
      if (wrData)
        dataByte <= wdataHeld[7:0];
      if (wrAddrLo)
        nvAddr[7:0] <= wdataHeld[7:0];
      if (wrAddrHi)
        nvAddr[9:8] <= wdataHeld[9:8];
    end
  end

  // Set wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      doneFlag <= 1'b0;
      enableReg <= nvm_pkg::ENABLE_RST;
    end
    else
    begin
      if (finish)
        doneFlag <= 1'b1;
      else if (doneClear)
        doneFlag <= 1'b0;
      if (wrEnable)
        enableReg <= wdataHeld[7:0] & nvm_pkg::ENABLE_RW_MASK;
    end
  end

  assign irq = doneFlag && enableReg[nvm_pkg::DONE_BIT];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  chk_unlock_reads_zero: assert property (
    ce && arvalid && arready && araddr == nvm_pkg::OFS_UNLOCK |=> rvalid && rdata == 32'h0)
    else $error("unlock port read returned nonzero data");

  chk_start_unlocked: assert property (
    ce && trigReq && !unlocked |=> !$rose(memReq))
    else $error("operation started without the unlock sequence");

  chk_space_choice: assert property (
    ce && start |=> memSpace == ($past(cfgSel) ? nvm_pkg::SPACE_CFG :
      ($past(pgmSel) ? nvm_pkg::SPACE_PROG : nvm_pkg::SPACE_DATA)))
    else $error("target space does not follow the select bits");

  chk_erase_follows_arm: assert property (
    ce && start |=> memReq && memErase == $past(eraseArm))
    else $error("erase flag does not follow erase arm");
  chk_allow_needed: assert property (
    $rose(memReq) |-> $past(writeAllow))
    else $error("operation started without write allow");
  chk_abort_on_reset: assert property (
    ce && resetEvt && busy |=> abortFlag && !memReq && dataByte == 8'h0)
    else $error("reset during operation did not abort and flag");
  chk_holding_cleared: assert property (
    ce && resetEvt |=> nvAddr == 10'h0 && dataByte == 8'h0)
    else $error("holding registers not cleared by reset event");
  chk_trigger_holds: assert property (
    ce && busy && !memDone && !resetEvt |=> busy [*1] ##0 ctrlView[nvm_pkg::CTRL_TRIG_BIT])
    else $error("trigger cleared before the operation ended");
  chk_done_sticky: assert property (
    doneFlag && !doneClear |=> doneFlag)
    else $error("done flag cleared without software");
  chk_done_on_finish: assert property (
    finish |=> doneFlag && !memReq)
    else $error("done flag not set at the end of an operation");
  chk_irq_follows: assert property (
    ce && wrEnable && doneFlag && !doneClear |=>
      irq == $past(wdataHeld[nvm_pkg::DONE_BIT]))
    else $error("interrupt does not follow the enable bit");

  cov_write_done: cover property (ce && start ##[1:50] finish);
  cov_erase: cover property (ce && start && eraseArm);
  cov_abort: cover property (ce && resetEvt && busy);
  cov_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// *** nv_unlock_seq.sv ***
// Purpose: Tracks the two-key unlock sequence written to the unlock port.
// Assumes: Key and consume pulses are qualified by the clock enable in the caller; reset events in breakSeq are not.
// Notes: Any other register write breaks the sequence.
`timescale 1ns/1ps
`default_nettype none
module nv_unlock_seq (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // Sequence events
  input wire logic keyWrite,
  input wire logic [7:0] keyData,
  input wire logic breakSeq,
  input wire logic consume,
  // Result
  output logic unlocked
);
  typedef enum logic [1:0]
  {
    LOCKED = 2'b00,
    FIRST_SEEN = 2'b01,
    OPEN = 2'b10
  } unlock_t;

  unlock_t state;
  unlock_t next_state;

  always_comb
  begin
    next_state = state;
    case (state)
      LOCKED:
        if (keyWrite && keyData == nvm_pkg::UNLOCK_KEY_FIRST)
          next_state = FIRST_SEEN;
      FIRST_SEEN:
        if (keyWrite)
          next_state = (keyData == nvm_pkg::UNLOCK_KEY_SECOND) ? OPEN : LOCKED;
        else if (breakSeq)
          next_state = LOCKED;
      OPEN:
        if (consume || keyWrite || breakSeq)
          next_state = LOCKED;
      default:
        next_state = LOCKED;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      state <= LOCKED;
    else if (ce)
      state <= next_state;
  end

  assign unlocked = (state == OPEN);
endmodule
`default_nettype wire

// *** nvm_pkg.sv ***
// Purpose: Constants for the nonvolatile write control block.
// Assumes: Byte registers, except the 10-bit address, on an AXI4-Lite slave with 32-bit data, one word each.
// Notes: Offsets are byte addresses; unused upper data bits read as zero.
package nvm_pkg;
  localparam int ADDR_W = 5;
  localparam int NV_ADDR_W = 10;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_UNLOCK = 5'h04;
  localparam logic [4:0] OFS_DATA = 5'h08;
  localparam logic [4:0] OFS_ADDR = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_ENABLE = 5'h14;
  localparam int CTRL_PGM_BIT = 7;
  localparam int CTRL_CFG_BIT = 6;
  localparam int CTRL_ERASE_BIT = 4;
  localparam int CTRL_ABORT_BIT = 3;
  localparam int CTRL_ALLOW_BIT = 2;
  localparam int CTRL_TRIG_BIT = 1;
  localparam int DONE_BIT = 4;
  localparam logic [7:0] ENABLE_RW_MASK = 8'h5f;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [9:0] NV_ADDR_RST = 10'h000;
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0]
  {
    SPACE_DATA = 2'b00,
    SPACE_PROG = 2'b01,
    SPACE_CFG = 2'b10
  } space_t;
endpackage

// *** tb_top.sv ***
// Purpose: Self-checking bench for the nonvolatile write control block.
// Assumes: Register map, unlock keys and response codes as in nvm_pkg.
// Notes: The bench plays the memory back end by pulsing memDone.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sysClk, rstn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, extPin, wdog, memReq, memErase, memDone, irq, ce;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, memSpace;
  logic [9:0] memAddr;
  logic [7:0] memData;
  logic [7:0] modes [4] = '{8'h04, 8'h84, 8'hc4, 8'h94};
  logic [1:0] spaces [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
  int nFail = 0;
  int checkCount = 0;

  nv_memory_write_control uut (
    .sys_clk(sysClk), .rstn(rstn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .extResetPinEvent(extPin), .watchdogResetEvent(wdog),
    .memReq(memReq), .memErase(memErase), .memSpace(memSpace),
    .memAddr(memAddr), .memData(memData), .memDone(memDone), .irq(irq)
  );

  initial
  begin
    sysClk = 1'b0;
    forever #12.5 sysClk = ~sysClk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checkCount++;
    if (got !== exp)
    begin
      nFail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Both ready lines stay high, so each answer is taken at the edge it is seen.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sysClk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge sysClk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    chk(32'(bresp), 32'(nvm_pkg::RESP_OKAY), "write response");
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge sysClk);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge sysClk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    chk(32'(rresp), 32'(er), "read response");
    if (er === nvm_pkg::RESP_OKAY)
      chk(rdata, exp, "read data");
  endtask

  // Selects go in first, since any register write between the keys breaks the unlock.
  task automatic start(input logic [7:0] c);
    wr(nvm_pkg::OFS_CTRL, c);
    wr(nvm_pkg::OFS_UNLOCK, nvm_pkg::UNLOCK_KEY_FIRST);
    wr(nvm_pkg::OFS_UNLOCK, nvm_pkg::UNLOCK_KEY_SECOND);
    wr(nvm_pkg::OFS_CTRL, c | 8'h02);
  endtask

  task automatic finish_op;
    @(posedge sysClk);
    memDone <= 1'b1;
    @(posedge sysClk);
    memDone <= 1'b0;
    repeat (2) @(posedge sysClk);
    chk(32'(memReq), 32'h0, "request after done");
  endtask

  initial
  begin
    {rstn, awvalid, wvalid, arvalid, extPin, wdog, memDone} = '0;
    {bready, rready, ce} = 3'b111;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (8) @(posedge sysClk);
    rstn <= 1'b1;
    rdc(nvm_pkg::OFS_CTRL, 32'h0, nvm_pkg::RESP_OKAY);
    rdc(nvm_pkg::OFS_ENABLE, 32'(nvm_pkg::ENABLE_RST), nvm_pkg::RESP_OKAY);
    wr(nvm_pkg::OFS_UNLOCK, nvm_pkg::UNLOCK_KEY_FIRST);
    rdc(nvm_pkg::OFS_UNLOCK, 32'h0, nvm_pkg::RESP_OKAY);
    rdc(5'h18, 32'h0, nvm_pkg::RESP_SLVERR);
    start(8'h00);
    chk(32'(memReq), 32'h0, "start without allow");
    rdc(nvm_pkg::OFS_CTRL, 32'h0, nvm_pkg::RESP_OKAY);
    wr(nvm_pkg::OFS_CTRL, 8'h04);
    wr(nvm_pkg::OFS_UNLOCK, nvm_pkg::UNLOCK_KEY_FIRST);
    wr(nvm_pkg::OFS_DATA, 8'h11);
    wr(nvm_pkg::OFS_UNLOCK, nvm_pkg::UNLOCK_KEY_SECOND);
    wr(nvm_pkg::OFS_CTRL, 8'h06);
    chk(32'(memReq), 32'h0, "broken unlock");
    wr(nvm_pkg::OFS_ENABLE, 8'h10);
    for (int i = 0; i < 4; i++)
    begin
      wr(nvm_pkg::OFS_DATA, 8'h3c + 8'(i));
      wr(nvm_pkg::OFS_ADDR, 8'h40 + 8'(i));
      start(modes[i]);
      chk(32'(memReq), 32'h1, "request");
      chk(32'(memSpace), 32'(spaces[i]), "space");
      chk(32'(memErase), 32'(modes[i][4]), "erase");
      chk({memAddr, memData}, 32'({10'h40, 8'h3c} + (i << 8) + i), "address and data");
      wr(nvm_pkg::OFS_CTRL, modes[i]);
      rdc(nvm_pkg::OFS_CTRL, 32'(modes[i] | 8'h02), nvm_pkg::RESP_OKAY);
      chk(32'(irq), 32'h0, "irq while busy");
      finish_op();
      rdc(nvm_pkg::OFS_CTRL, 32'(modes[i]), nvm_pkg::RESP_OKAY);
      if (!modes[i][4])
      begin
        chk(32'(irq), 32'h1, "irq after write");
        rdc(nvm_pkg::OFS_STATUS, 32'h10, nvm_pkg::RESP_OKAY);
      end
      wr(nvm_pkg::OFS_STATUS, 8'h10);
      chk(32'(irq), 32'h0, "irq after clear");
    end
    wr(nvm_pkg::OFS_ENABLE, 8'h00);
    start(8'h04);
    // A done pulse while the clock enable is low must not end the operation.
    @(posedge sysClk);
    ce <= 1'b0;
    memDone <= 1'b1;
    repeat (2) @(posedge sysClk);
    {ce, memDone} <= 2'b10;
    @(posedge sysClk);
    chk(32'(memReq), 32'h1, "request while clock enable low");
    rdc(nvm_pkg::OFS_STATUS, 32'h0, nvm_pkg::RESP_OKAY);
    finish_op();
    chk(32'(irq), 32'h0, "masked irq");
    rdc(nvm_pkg::OFS_STATUS, 32'h10, nvm_pkg::RESP_OKAY);
    wr(nvm_pkg::OFS_ENABLE, 8'h10);
    chk(32'(irq), 32'h1, "unmasked irq");
    wr(nvm_pkg::OFS_STATUS, 8'h10);
    for (int k = 0; k < 2; k++)
    begin
      wr(nvm_pkg::OFS_DATA, 8'h5a);
      wr(nvm_pkg::OFS_ADDR, 8'h77);
      start(8'h04);
      @(posedge sysClk);
      extPin <= (k == 0);
      wdog <= (k == 1);
      @(posedge sysClk);
      {extPin, wdog} <= 2'b00;
      repeat (2) @(posedge sysClk);
      chk(32'(memReq), 32'h0, "request after reset event");
      rdc(nvm_pkg::OFS_CTRL, 32'h08, nvm_pkg::RESP_OKAY);
      rdc(nvm_pkg::OFS_DATA, 32'h0, nvm_pkg::RESP_OKAY);
      rdc(nvm_pkg::OFS_ADDR, 32'h0, nvm_pkg::RESP_OKAY);
      wr(nvm_pkg::OFS_CTRL, 8'h00);
    end
    report_and_stop();
  end

  // The sequence needs a few hundred cycles; twenty thousand means a hang.
  initial
  begin
    #(25 * 20000);
    nFail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
